// ===== design/led_matrix_pkg.sv
// Purpose: shared constants and types for the LED matrix control block
// Assumes: 40 MHz system clock, byte-wide register map behind an I2C slave
package led_matrix_pkg;
	localparam int CLK_MHZ = 40;
	localparam int COLS = 18;
	localparam int ROWS = 11;
	localparam int DOTS = COLS * ROWS;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // Arbitrary value
	localparam logic [7:0] PAGE_DUTY = 8'h00;
	localparam logic [7:0] PAGE_SCALE = 8'h01;
	localparam logic [7:0] PAGE_FUNC = 8'h02;
	localparam logic [7:0] ADDR_LOCK = 8'hFE;
	localparam logic [7:0] ADDR_PAGE = 8'hFD;
	localparam logic [7:0] ADDR_ID = 8'hFC;
	localparam logic [7:0] LOCK_KEY = 8'hC5;
	localparam logic [7:0] RESET_KEY = 8'hAE;
	localparam logic [7:0] DOT_FIRST = 8'h01;
	localparam logic [7:0] DOT_LAST = 8'hC6;
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_GCC = 8'h01;
	localparam logic [7:0] REG_PULL = 8'h02;
	localparam logic [7:0] REG_FAULT_FIRST = 8'h03;
	localparam logic [7:0] REG_FAULT_LAST = 8'h23;
	localparam logic [7:0] REG_THERM = 8'h24;
	localparam logic [7:0] REG_SPREAD = 8'h25;
	localparam logic [7:0] REG_RESET = 8'h2F;
	localparam logic [7:0] CFG_RESET = 8'h08;
	localparam logic [7:0] PULL_RESET = 8'h33;
	localparam logic [7:0] ZERO_RESET = 8'h00;
	localparam logic [7:0] PULL_MASK = 8'hF7;
	localparam logic [7:0] THERM_MASK = 8'h0F;
	localparam logic [7:0] SPREAD_MASK = 8'hDF;
	localparam int FAULT_BITS = 6;
	localparam int CFG_SCAN_LSB = 4;
	localparam int CFG_LGC_BIT = 3;
	localparam int CFG_FD_LSB = 1;
	localparam int CFG_RUN_BIT = 0;
	localparam int PULL_PHASE_BIT = 7;
	localparam int PULL_ROW_LSB = 4;
	localparam int PULL_COL_LSB = 0;
	localparam int THERM_TS_LSB = 2;
	localparam int THERM_DR_LSB = 0;
	localparam int SPR_SYNC_LSB = 6;
	localparam int SPR_EN_BIT = 4;
	localparam int SPR_RNG_LSB = 2;
	localparam int SPR_CLT_LSB = 0;
	localparam logic [1:0] FD_OFF = 2'b00;
	localparam logic [1:0] FD_OPEN = 2'b01;
	localparam logic [1:0] FD_SHORT = 2'b10;
	localparam logic [3:0] SCAN_STATIC = 4'hA;
	localparam logic [3:0] SCAN_LAST_ROW = 4'hA;
	localparam logic [1:0] SYNC_SLAVE = 2'b10;
	localparam logic [1:0] SYNC_MASTER = 2'b11;
	localparam int FAULT_PASS_FRAMES = 2;
	// Scan slot timing drives a phase accumulator, 256 steps per slot
	localparam int SCAN_SLOT_US = 33;
	localparam int SLOT_CYC = SCAN_SLOT_US * CLK_MHZ;
	localparam logic [15:0] TICK_INCR = 16'((65536 * 256) / SLOT_CYC);
	localparam logic [15:0] SPREAD_DELTA [4] = '{16'(TICK_INCR * 5 / 100),
		16'(TICK_INCR * 15 / 100), 16'(TICK_INCR * 24 / 100), 16'(TICK_INCR * 34 / 100)};
	localparam int SPREAD_US0 = 1980;
	localparam int SPREAD_US1 = 1200;
	localparam int SPREAD_US2 = 820;
	localparam int SPREAD_US3 = 660;
	localparam int SPREAD_CYC0 = SPREAD_US0 * CLK_MHZ;
	localparam int SPREAD_CYC1 = SPREAD_US1 * CLK_MHZ;
	localparam int SPREAD_CYC2 = SPREAD_US2 * CLK_MHZ;
	localparam int SPREAD_CYC3 = SPREAD_US3 * CLK_MHZ;
	localparam logic [6:0] DERATE_PCT [4] = '{7'h64, 7'h4B, 7'h37, 7'h1E};
	typedef enum logic [4:0] {
		I2C_IDLE = 5'b00001,
		I2C_RECV = 5'b00010,
		I2C_ACK = 5'b00100,
		I2C_SEND = 5'b01000,
		I2C_MACK = 5'b10000
	} i2c_state_type;
	typedef enum logic [2:0] {
		KIND_ADDR = 3'b001,
		KIND_REG = 3'b010,
		KIND_DATA = 3'b100
	} byte_kind_type;
endpackage

// ===== design/pin_sync.sv
// Purpose: two-stage synchroniser for asynchronous pin inputs
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	// Two flops, reset to zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= '0;
			dout <= '0;
		end
		else
		begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// ===== design/dot_duty_gen.sv
// Purpose: per-column duty compare and pull-up enable for the active row
// Assumes: count steps once per scan tick within a row slot
// Notes: phase select 1 mirrors odd columns to the end of the slot
`timescale 1ns/1ps
module dot_duty_gen #(
	parameter int COLS = 18
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic phaseSel,
	input wire logic [7:0] count,
	input wire logic [COLS*8-1:0] rowDuty,
	input wire logic [2:0] pullCode,
	output logic [COLS-1:0] sinkOn,
	output logic [COLS-1:0] pullupEn
);
	genvar c;
	generate
		for (c = 0; c < COLS; c++)
		begin : g_col
			logic [7:0] cmp;
			// Odd columns count down under phase select 1 to spread load
			assign cmp = (phaseSel && c[0]) ? ~count : count;
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					sinkOn[c] <= 1'b0;
				else
					sinkOn[c] <= enable && (cmp < rowDuty[c*8 +: 8]);
			end
			// Switched codes only while the column sink is off
			assign pullupEn[c] = (pullCode != 3'h0) && (pullCode[2] || !sinkOn[c]);
		end
	endgenerate
endmodule

// ===== design/led_matrix_control_registers.sv
// Purpose: paged register bank, I2C slave and scan control for an LED matrix
// Assumes: SCL and SDA are sampled by sys_clk, SCL well below sys_clk / 4
// Notes: analog sinks, switches and pull resistors sit outside this block
`timescale 1ns/1ps
module led_matrix_control_registers #(
	parameter logic [6:0] DEV_ADDR = led_matrix_pkg::DEV_ADDR_DEFAULT,
	parameter int SPREAD_CYC0 = led_matrix_pkg::SPREAD_CYC0,
	parameter int SPREAD_CYC1 = led_matrix_pkg::SPREAD_CYC1,
	parameter int SPREAD_CYC2 = led_matrix_pkg::SPREAD_CYC2,
	parameter int SPREAD_CYC3 = led_matrix_pkg::SPREAD_CYC3
)(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sclPin,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic syncIn,
	output logic syncOut,
	output logic syncOe,
	input wire logic thermalAlarm,
	input wire logic [17:0] faultSense,
	output logic [10:0] rowSwitchOutputs,
	output logic [17:0] columnSinkOutputs,
	output logic [143:0] columnScaleLevel,
	output logic [7:0] globalCurrentLevel,
	output logic [6:0] deratePercent,
	output logic [1:0] thermalThresholdSelect,
	output logic logicThresholdSelect,
	output logic [2:0] rowPulldownSelect,
	output logic [10:0] rowPulldownEnable,
	output logic [2:0] columnPullupSelect,
	output logic [17:0] columnPullupEnable,
	output logic [1:0] faultDetectMode,
	output logic faultBusy
);
	localparam int C = led_matrix_pkg::COLS;
	localparam int R = led_matrix_pkg::ROWS;
	localparam int D = led_matrix_pkg::DOTS;

	// Pin inputs pass two flops before any logic
	logic [21:0] pinS;
	logic sclS, sdaS, syncS, hotS;
	logic [17:0] senseS;
	pin_sync #(.WIDTH(22)) u_sync (
		.clk(sys_clk),
		.rstn(rstn),
		.din({sclPin, sdaIn, syncIn, thermalAlarm, faultSense}),
		.dout(pinS)
	);
	assign {sclS, sdaS, syncS, hotS, senseS} = pinS;

	logic sclPrev_q, sdaPrev_q, syncPrev_q;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			syncPrev_q <= 1'b0;
		end
		else
		begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
			syncPrev_q <= syncS;
		end
	end

	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise = sclS && !sclPrev_q;
	assign sclFall = !sclS && sclPrev_q;
	assign startCond = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign stopCond = sclS && sclPrev_q && !sdaPrev_q && sdaS;

	// Register storage
	logic [7:0] dutyMem [D];
	logic [7:0] scaleMem [D];
	logic [7:0] cfg_q, gcc_q, pull_q, therm_q, spread_q, page_q, lock_q;
	logic [D-1:0] faultMap_q;

	// I2C engine state
	led_matrix_pkg::i2c_state_type i2cState_q;
	led_matrix_pkg::byte_kind_type kind_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q, tx_q, ptr_q, wrAddr_q, wrData_q;
	logic isRead_q, mAck_q, sdaOe_q, wrStb_q;
	logic [7:0] rdData;

	// Read mux follows the register pointer
	logic [7:0] rdIdx;
	always_comb
	begin
		rdData = 8'h00;
		rdIdx = ptr_q - led_matrix_pkg::DOT_FIRST;
		if (ptr_q == led_matrix_pkg::ADDR_LOCK)
			rdData = lock_q;
		else if (ptr_q == led_matrix_pkg::ADDR_ID)
			rdData = {1'b0, DEV_ADDR};
		else if (page_q == led_matrix_pkg::PAGE_FUNC)
		begin
			case (ptr_q)
				led_matrix_pkg::REG_CFG: rdData = cfg_q;
				led_matrix_pkg::REG_GCC: rdData = gcc_q;
				led_matrix_pkg::REG_PULL: rdData = pull_q;
				led_matrix_pkg::REG_THERM: rdData = therm_q;
				led_matrix_pkg::REG_SPREAD: rdData = spread_q;
				default:
				begin
					rdIdx = ptr_q - led_matrix_pkg::REG_FAULT_FIRST;
					if (ptr_q >= led_matrix_pkg::REG_FAULT_FIRST &&
						ptr_q <= led_matrix_pkg::REG_FAULT_LAST)
						rdData = {2'b00, faultMap_q[rdIdx*6 +: 6]};
				end
			endcase
		end
		else if (ptr_q >= led_matrix_pkg::DOT_FIRST && ptr_q <= led_matrix_pkg::DOT_LAST)
		begin
			if (page_q == led_matrix_pkg::PAGE_DUTY)
				rdData = dutyMem[rdIdx];
			else if (page_q == led_matrix_pkg::PAGE_SCALE)
				rdData = scaleMem[rdIdx];
		end
	end

	// I2C slave: bit engine, ack and pointer
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			i2cState_q <= led_matrix_pkg::I2C_IDLE;
			kind_q <= led_matrix_pkg::KIND_ADDR;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			isRead_q <= 1'b0;
			mAck_q <= 1'b0;
			sdaOe_q <= 1'b0;
			wrStb_q <= 1'b0;
			wrAddr_q <= 8'h00;
			wrData_q <= 8'h00;
		end
		else
		begin
			wrStb_q <= 1'b0;
			if (startCond)
			begin
				i2cState_q <= led_matrix_pkg::I2C_RECV;
				kind_q <= led_matrix_pkg::KIND_ADDR;
				bitCnt_q <= 4'h0;
				sdaOe_q <= 1'b0;
			end
			else if (stopCond)
			begin
				i2cState_q <= led_matrix_pkg::I2C_IDLE;
				sdaOe_q <= 1'b0;
			end
			else
			begin
				case (i2cState_q)
					led_matrix_pkg::I2C_IDLE: sdaOe_q <= 1'b0;
					led_matrix_pkg::I2C_RECV:
					begin
						if (sclRise)
						begin
							shift_q <= {shift_q[6:0], sdaS};
							bitCnt_q <= bitCnt_q + 4'h1;
						end
						else if (sclFall && bitCnt_q == 4'h8)
						begin
							i2cState_q <= led_matrix_pkg::I2C_ACK;
							sdaOe_q <= 1'b1;
							case (kind_q)
								led_matrix_pkg::KIND_ADDR:
								begin
									isRead_q <= shift_q[0];
									if (shift_q[7:1] != DEV_ADDR)
									begin
										i2cState_q <= led_matrix_pkg::I2C_IDLE;
										sdaOe_q <= 1'b0;
									end
								end
								led_matrix_pkg::KIND_REG: ptr_q <= shift_q;
								default:
								begin
									wrStb_q <= 1'b1;
									wrAddr_q <= ptr_q;
									wrData_q <= shift_q;
									ptr_q <= ptr_q + 8'h01;
								end
							endcase
						end
					end
					led_matrix_pkg::I2C_ACK:
					begin
						if (sclFall)
						begin
							bitCnt_q <= 4'h0;
							if (isRead_q)
							begin
								tx_q <= {rdData[6:0], 1'b0};
								sdaOe_q <= !rdData[7];
								ptr_q <= ptr_q + 8'h01;
								i2cState_q <= led_matrix_pkg::I2C_SEND;
							end
							else
							begin
								sdaOe_q <= 1'b0;
								i2cState_q <= led_matrix_pkg::I2C_RECV;
								kind_q <= (kind_q == led_matrix_pkg::KIND_ADDR) ?
									led_matrix_pkg::KIND_REG : led_matrix_pkg::KIND_DATA;
							end
						end
					end
					led_matrix_pkg::I2C_SEND:
					begin
						if (sclFall && bitCnt_q == 4'h7)
						begin
							sdaOe_q <= 1'b0;
							i2cState_q <= led_matrix_pkg::I2C_MACK;
						end
						else if (sclFall)
						begin
							sdaOe_q <= !tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
							bitCnt_q <= bitCnt_q + 4'h1;
						end
					end
					led_matrix_pkg::I2C_MACK:
					begin
						// Master ack continues the read, nack ends it
						if (sclRise)
							mAck_q <= !sdaS;
						else if (sclFall && mAck_q)
						begin
							bitCnt_q <= 4'h0;
							tx_q <= {rdData[6:0], 1'b0};
							sdaOe_q <= !rdData[7];
							ptr_q <= ptr_q + 8'h01;
							i2cState_q <= led_matrix_pkg::I2C_SEND;
						end
						else if (sclFall)
							i2cState_q <= led_matrix_pkg::I2C_IDLE;
					end
					default: i2cState_q <= led_matrix_pkg::I2C_IDLE;
				endcase
			end
		end
	end
	assign sdaOut = 1'b0; // Open drain: only ever pulls low
	assign sdaOe = sdaOe_q;

	// Write decode
	logic funcWr, dotWr, regClear, faultStart;
	logic [7:0] dotIdx;
	assign funcWr = wrStb_q && page_q == led_matrix_pkg::PAGE_FUNC;
	assign dotIdx = wrAddr_q - led_matrix_pkg::DOT_FIRST;
	assign dotWr = wrStb_q && (page_q == led_matrix_pkg::PAGE_DUTY ||
		page_q == led_matrix_pkg::PAGE_SCALE) && wrAddr_q >= led_matrix_pkg::DOT_FIRST &&
		wrAddr_q <= led_matrix_pkg::DOT_LAST;
	assign regClear = funcWr && wrAddr_q == led_matrix_pkg::REG_RESET &&
		wrData_q == led_matrix_pkg::RESET_KEY;
	// Pass only from 00, so holding 01 never retriggers
	assign faultStart = funcWr && wrAddr_q == led_matrix_pkg::REG_CFG &&
		cfg_q[led_matrix_pkg::CFG_FD_LSB +: 2] == led_matrix_pkg::FD_OFF &&
		(wrData_q[led_matrix_pkg::CFG_FD_LSB +: 2] == led_matrix_pkg::FD_OPEN ||
		wrData_q[led_matrix_pkg::CFG_FD_LSB +: 2] == led_matrix_pkg::FD_SHORT);

	// Dot duty and scale bytes
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < D; i++)
			begin
				dutyMem[i] <= led_matrix_pkg::ZERO_RESET;
				scaleMem[i] <= led_matrix_pkg::ZERO_RESET;
			end
		end
		else if (regClear)
		begin
			for (int i = 0; i < D; i++)
			begin
				dutyMem[i] <= led_matrix_pkg::ZERO_RESET;
				scaleMem[i] <= led_matrix_pkg::ZERO_RESET;
			end
		end
		else if (dotWr && page_q == led_matrix_pkg::PAGE_DUTY)
			dutyMem[dotIdx] <= wrData_q;
		else if (dotWr)
			scaleMem[dotIdx] <= wrData_q;
	end

	// Page pointer behind a single-use lock
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			page_q <= led_matrix_pkg::PAGE_DUTY;
			lock_q <= led_matrix_pkg::ZERO_RESET;
		end
		else if (regClear)
		begin
			page_q <= led_matrix_pkg::PAGE_DUTY;
			lock_q <= led_matrix_pkg::ZERO_RESET;
		end
		else if (wrStb_q && wrAddr_q == led_matrix_pkg::ADDR_LOCK)
			lock_q <= wrData_q;
		else if (wrStb_q && wrAddr_q == led_matrix_pkg::ADDR_PAGE)
		begin
			if (lock_q == led_matrix_pkg::LOCK_KEY)
				page_q <= wrData_q;
			lock_q <= led_matrix_pkg::ZERO_RESET;
		end
	end

	// Function registers, reserved bits masked
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_q <= led_matrix_pkg::CFG_RESET;
			gcc_q <= led_matrix_pkg::ZERO_RESET;
			pull_q <= led_matrix_pkg::PULL_RESET;
			therm_q <= led_matrix_pkg::ZERO_RESET;
			spread_q <= led_matrix_pkg::ZERO_RESET;
		end
		else if (regClear)
		begin
			cfg_q <= led_matrix_pkg::CFG_RESET;
			gcc_q <= led_matrix_pkg::ZERO_RESET;
			pull_q <= led_matrix_pkg::PULL_RESET;
			therm_q <= led_matrix_pkg::ZERO_RESET;
			spread_q <= led_matrix_pkg::ZERO_RESET;
		end
		else if (funcWr)
		begin
			case (wrAddr_q)
				led_matrix_pkg::REG_CFG: cfg_q <= wrData_q;
				led_matrix_pkg::REG_GCC: gcc_q <= wrData_q;
				led_matrix_pkg::REG_PULL: pull_q <= wrData_q & led_matrix_pkg::PULL_MASK;
				led_matrix_pkg::REG_THERM: therm_q <= wrData_q & led_matrix_pkg::THERM_MASK;
				led_matrix_pkg::REG_SPREAD: spread_q <= wrData_q & led_matrix_pkg::SPREAD_MASK;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	logic runBit, staticMode, spreadOn, master, slave;
	logic [3:0] scanCode, lastRow;
	assign runBit = cfg_q[led_matrix_pkg::CFG_RUN_BIT];
	assign scanCode = cfg_q[led_matrix_pkg::CFG_SCAN_LSB +: 4];
	assign staticMode = scanCode >= led_matrix_pkg::SCAN_STATIC;
	assign lastRow = staticMode ? 4'h0 : led_matrix_pkg::SCAN_LAST_ROW - scanCode;
	assign spreadOn = spread_q[led_matrix_pkg::SPR_EN_BIT];
	assign master = spread_q[led_matrix_pkg::SPR_SYNC_LSB +: 2] == led_matrix_pkg::SYNC_MASTER;
	assign slave = spread_q[led_matrix_pkg::SPR_SYNC_LSB +: 2] == led_matrix_pkg::SYNC_SLAVE;

	// Spread sweep: step direction flips every half modulation period
	logic [16:0] sweepCnt_q, halfPeriod;
	logic sweepUp_q;
	always_comb
	begin
		case (spread_q[led_matrix_pkg::SPR_CLT_LSB +: 2])
			2'b00: halfPeriod = 17'(SPREAD_CYC0 / 2);
			2'b01: halfPeriod = 17'(SPREAD_CYC1 / 2);
			2'b10: halfPeriod = 17'(SPREAD_CYC2 / 2);
			default: halfPeriod = 17'(SPREAD_CYC3 / 2);
		endcase
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sweepCnt_q <= 17'h0;
			sweepUp_q <= 1'b0;
		end
		else if (sweepCnt_q + 17'h1 >= halfPeriod)
		begin
			sweepCnt_q <= 17'h0;
			sweepUp_q <= !sweepUp_q;
		end
		else
			sweepCnt_q <= sweepCnt_q + 17'h1;
	end

	// Phase accumulator makes the internal scan tick
	logic [15:0] acc_q, incr, delta;
	logic tickInt_q;
	assign delta = led_matrix_pkg::SPREAD_DELTA[spread_q[led_matrix_pkg::SPR_RNG_LSB +: 2]];
	assign incr = !spreadOn ? led_matrix_pkg::TICK_INCR : sweepUp_q ?
		led_matrix_pkg::TICK_INCR + delta : led_matrix_pkg::TICK_INCR - delta;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_q <= 16'h0;
			tickInt_q <= 1'b0;
		end
		else
			{tickInt_q, acc_q} <= {1'b0, acc_q} + {1'b0, incr};
	end

	// Clock sharing: master toggles pin per tick, slave counts both edges
	logic syncOut_q, pwmTick;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			syncOut_q <= 1'b0;
		else if (master && tickInt_q)
			syncOut_q <= !syncOut_q;
	end
	assign syncOut = syncOut_q;
	assign syncOe = master;
	assign pwmTick = slave ? (syncS != syncPrev_q) : tickInt_q;

	// Slot counter and row scan, cleared to zero while shut down
	logic [7:0] cnt_q;
	logic [3:0] row_q;
	logic slotEnd;
	assign slotEnd = runBit && pwmTick && cnt_q == 8'hFF;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= 8'h00;
			row_q <= 4'h0;
		end
		else if (!runBit || row_q > lastRow)
		begin
			cnt_q <= 8'h00;
			row_q <= 4'h0;
		end
		else if (pwmTick)
		begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == 8'hFF)
				row_q <= (row_q == lastRow) ? 4'h0 : row_q + 4'h1;
		end
	end

	// Gather the active row's bytes
	logic [C*8-1:0] rowDuty, rowScale;
	always_comb
	begin
		for (int c = 0; c < C; c++)
		begin
			rowDuty[c*8 +: 8] = dutyMem[int'(row_q) * C + c];
			rowScale[c*8 +: 8] = scaleMem[int'(row_q) * C + c];
		end
	end

	dot_duty_gen #(.COLS(C)) u_duty (
		.clk(sys_clk),
		.rstn(rstn),
		.enable(runBit),
		.phaseSel(pull_q[led_matrix_pkg::PULL_PHASE_BIT]),
		.count(cnt_q),
		.rowDuty(rowDuty),
		.pullCode(pull_q[led_matrix_pkg::PULL_COL_LSB +: 3]),
		.sinkOn(columnSinkOutputs),
		.pullupEn(columnPullupEnable)
	);

	// Row switches, scale and derating, all registered
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rowSwitchOutputs <= 11'h000;
			columnScaleLevel <= '0;
			deratePercent <= led_matrix_pkg::DERATE_PCT[0];
		end
		else
		begin
			for (int r = 0; r < R; r++)
				rowSwitchOutputs[r] <= runBit && !staticMode && row_q == 4'(r);
			columnScaleLevel <= rowScale;
			deratePercent <= hotS ? led_matrix_pkg::DERATE_PCT[therm_q[1:0]] :
				led_matrix_pkg::DERATE_PCT[0];
		end
	end

	// Row pull-downs switch off while the row is on for codes 1..3
	always_comb
	begin
		for (int r = 0; r < R; r++)
			rowPulldownEnable[r] = pull_q[6:4] != 3'h0 &&
				(pull_q[6] || !rowSwitchOutputs[r]);
	end

	// Fault pass: capture sense at each slot end until the second frame end
	logic [1:0] frames_q;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			faultBusy <= 1'b0;
			frames_q <= 2'h0;
			faultMap_q <= '0;
		end
		else if (regClear)
		begin
			faultBusy <= 1'b0;
			frames_q <= 2'h0;
			faultMap_q <= '0;
		end
		else if (faultStart)
		begin
			faultBusy <= 1'b1;
			frames_q <= 2'h0;
		end
		else if (faultBusy && slotEnd)
		begin
			faultMap_q[int'(row_q) * C +: C] <= senseS;
			if (row_q == lastRow)
			begin
				frames_q <= frames_q + 2'h1;
				if (frames_q == 2'(led_matrix_pkg::FAULT_PASS_FRAMES - 1))
					faultBusy <= 1'b0;
			end
		end
	end
	assign faultDetectMode = faultBusy ? cfg_q[led_matrix_pkg::CFG_FD_LSB +: 2] : 2'b00;

	assign globalCurrentLevel = gcc_q;
	assign thermalThresholdSelect = therm_q[led_matrix_pkg::THERM_TS_LSB +: 2];
	assign logicThresholdSelect = cfg_q[led_matrix_pkg::CFG_LGC_BIT];
	assign rowPulldownSelect = pull_q[led_matrix_pkg::PULL_ROW_LSB +: 3];
	assign columnPullupSelect = pull_q[led_matrix_pkg::PULL_COL_LSB +: 3];
endmodule

// ===== testbench/led_matrix_control_registers_assertions.sv
// Purpose: port checks for the LED matrix block
// Assumes: only top ports are visible
// Notes: pull checks cover the comb decode
`timescale 1ns/1ps
module led_matrix_control_registers_assertions (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sdaOut,
	input wire logic thermalAlarm,
	input wire logic faultBusy,
	input wire logic [1:0] faultDetectMode,
	input wire logic [6:0] deratePercent,
	input wire logic [10:0] rowSwitchOutputs,
	input wire logic [10:0] rowPulldownEnable,
	input wire logic [2:0] rowPulldownSelect,
	input wire logic [17:0] columnSinkOutputs,
	input wire logic [17:0] columnPullupEnable,
	input wire logic [2:0] columnPullupSelect
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// A pass spans frames, a blip means a broken counter
	sequence s_pass;
		faultBusy [*8];
	endsequence
	property p_sda; sdaOut == 1'b0; endproperty
	a_sda: assert property (p_sda) else $error("data pin driven high");
	property p_row; $onehot0(rowSwitchOutputs); endproperty
	a_row: assert property (p_row) else $error("two rows on");
	property p_rpd; rowPulldownEnable == (rowPulldownSelect == 3'h0 ? 11'h000 :
		rowPulldownSelect[2] ? 11'h7FF : ~rowSwitchOutputs); endproperty
	a_rpd: assert property (p_rpd) else $error("row pull wrong");
	property p_cpu; columnPullupEnable == (columnPullupSelect == 3'h0 ? 18'h00000 :
		columnPullupSelect[2] ? 18'h3FFFF : ~columnSinkOutputs); endproperty
	a_cpu: assert property (p_cpu) else $error("column pull wrong");
	property p_der; !thermalAlarm [*4] |=> deratePercent == 7'h64; endproperty
	a_der: assert property (p_der) else $error("derated while cool");
	property p_mb; faultBusy |-> faultDetectMode inside {2'h1, 2'h2}; endproperty
	a_mb: assert property (p_mb) else $error("bad pass mode");
	property p_mi; !faultBusy |-> faultDetectMode == 2'h0; endproperty
	a_mi: assert property (p_mi) else $error("mode without pass");
	property p_pass; $rose(faultBusy) |-> s_pass; endproperty
	a_pass: assert property (p_pass) else $error("pass too short");
endmodule
bind led_matrix_control_registers led_matrix_control_registers_assertions u_chk(.sys_clk,
	.rstn, .sdaOut, .thermalAlarm, .faultBusy, .faultDetectMode, .deratePercent,
	.rowSwitchOutputs, .rowPulldownEnable, .rowPulldownSelect, .columnSinkOutputs,
	.columnPullupEnable, .columnPullupSelect);

// ===== testbench/i2c_host_model.sv
// Purpose: I2C host that drives the register port
// Assumes: 200 ns SCL, pulled-up data line
// Notes: no clock stretching
`timescale 1ns/1ps
module i2c_host_model #(
	parameter logic [6:0] ADDR = led_matrix_pkg::DEV_ADDR_DEFAULT
)(
	output logic scl,
	output logic sda,
	input wire logic sdaLine
);
	// Released bus idles high
	initial {scl, sda} = 2'b11;
	task bt(input logic b, output logic r);
		sda = b;
		#50 scl = 1'b1;
		#50 r = sdaLine;
		#50 scl = 1'b0;
		#50;
	endtask
	task by(input logic [7:0] d, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
		bt(1'b1, a);
	endtask
	task st;
		sda = 1'b1;
		#50 scl = 1'b1;
		#50 sda = 1'b0;
		#50 scl = 1'b0;
		#50;
	endtask
	task sp;
		sda = 1'b0;
		#50 scl = 1'b1;
		#50 sda = 1'b1;
		#100;
	endtask
	task wr(input logic [7:0] r, input logic [7:0] d);
		logic [7:0] x;
		st;
		by({ADDR, 1'b0}, x);
		by(r, x);
		by(d, x);
		sp;
	endtask
	// Last read byte ends with a NACK
	task rd(input logic [7:0] r, output logic [7:0] q);
		st;
		by({ADDR, 1'b0}, q);
		by(r, q);
		st;
		by({ADDR, 1'b1}, q);
		by(8'hFF, q);
		sp;
	endtask
	// Key first, the page write is taken once
	task pg(input logic [7:0] p);
		wr(8'hFE, 8'hC5);
		wr(8'hFD, p);
	endtask
endmodule

// ===== testbench/led_matrix_control_registers_tb_top.sv
// Purpose: self-checking bench for the LED matrix block
// Assumes: host model on the I2C port
// Notes: fault sense held at one pattern
`timescale 1ns/1ps
module led_matrix_control_registers_tb_top;
	typedef struct packed {logic [7:0] pg, ra, wd; logic w; logic [7:0] ex;} row_type;
	logic sys_clk = 1'b0, rstn = 1'b0, sclPin, hostSda, sdaOe, faultBusy;
	logic [17:0] faultSense = 18'h0002A, columnSinkOutputs;
	logic [10:0] rowSwitchOutputs, seen;
	logic [7:0] globalCurrentLevel, q;
	int nMismatch = 0, numChecks = 0;
	row_type rows[10] = '{'{8'h02, 8'h00, 8'h00, 1'b0, 8'h08}, '{8'h02, 8'h02, 8'h00, 1'b0, 8'h33},
		'{8'h02, 8'h02, 8'hFF, 1'b1, 8'hF7}, '{8'h02, 8'h24, 8'hFF, 1'b1, 8'h0F},
		'{8'h02, 8'h25, 8'hFF, 1'b1, 8'hDF}, '{8'h02, 8'h01, 8'h0F, 1'b1, 8'h0F},
		'{8'h02, 8'h30, 8'h11, 1'b1, 8'h00}, '{8'h00, 8'hC6, 8'h5A, 1'b1, 8'h5A},
		'{8'h01, 8'h01, 8'hA5, 1'b1, 8'hA5}, '{8'h00, 8'hC7, 8'h5A, 1'b1, 8'h00}};
	// Open-drain data line with pull-up
	wire sdaIn = hostSda & ~sdaOe;
	initial forever #12.5 sys_clk = ~sys_clk;
	i2c_host_model u_i2c_host_model(.scl(sclPin), .sda(hostSda), .sdaLine(sdaIn));
	led_matrix_control_registers u_led_matrix_control_registers(.sys_clk, .rstn, .sclPin,
		.sdaIn, .sdaOut(), .sdaOe, .syncIn(1'b0), .syncOut(), .syncOe(), .thermalAlarm(1'b0),
		.faultSense, .rowSwitchOutputs, .columnSinkOutputs, .columnScaleLevel(),
		.globalCurrentLevel, .deratePercent(), .thermalThresholdSelect(),
		.logicThresholdSelect(), .rowPulldownSelect(), .rowPulldownEnable(),
		.columnPullupSelect(), .columnPullupEnable(), .faultDetectMode(), .faultBusy);
	task chk(input logic [17:0] s, input logic [17:0] e);
		numChecks++;
		if (s !== e)
		begin
			nMismatch++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Table rows first, then the awkward cases
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		// Host steps land on falling edges, away from the sampling edge
		repeat (4) @(negedge sys_clk);
		foreach (rows[i])
		begin
			u_i2c_host_model.pg(rows[i].pg);
			if (rows[i].w) u_i2c_host_model.wr(rows[i].ra, rows[i].wd);
			u_i2c_host_model.rd(rows[i].ra, q);
			chk(q, rows[i].ex);
		end
		$display("table done");
		u_i2c_host_model.wr(8'hFD, 8'h02);
		u_i2c_host_model.rd(8'hC6, q);
		chk(q, 8'h5A);
		u_i2c_host_model.pg(8'h02);
		u_i2c_host_model.wr(8'h00, 8'h91);
		seen = 11'h000;
		repeat (4000) @(negedge sys_clk) seen |= rowSwitchOutputs;
		chk(seen, 11'h003);
		chk(globalCurrentLevel, 8'h0F);
		$display("scan done");
		// Current already at 0x0F before the open pass
		u_i2c_host_model.wr(8'h00, 8'h03);
		chk(faultBusy, 1'b1);
		for (int i = 0; i < 60000 && faultBusy !== 1'b0; i++) @(negedge sys_clk);
		if (faultBusy !== 1'b0)
		begin
			nMismatch++;
			results;
		end
		u_i2c_host_model.rd(8'h03, q);
		chk(q, 8'h2A);
		u_i2c_host_model.wr(8'h00, 8'h03);
		chk(faultBusy, 1'b0);
		$display("fault done");
		u_i2c_host_model.wr(8'h2F, 8'hAE);
		u_i2c_host_model.rd(8'hC6, q);
		chk(q, 8'h00);
		$display("reset done");
		results;
	end
endmodule
